// >>> src/phy_cfg_pkg.sv
// constants for the loopback and MAC interface configuration registers
// assumes an AXI4-Lite master with 32-bit data and word-aligned access
package phy_cfg_pkg;
   // register word indices; byte address is four times the index
   localparam logic [7:0] IDX_TX_FIFO_CFG = 8'h11;
   localparam logic [7:0] IDX_LOOPBACK = 8'h16;
   localparam logic [7:0] IDX_MAC_CFG = 8'h17;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h19;
   localparam int ADDR_W = 10;

   localparam logic [15:0] LOOPBACK_RESET = 16'h0100;
   localparam logic [15:0] MAC_CFG_RESET = 16'h4001;
   localparam logic [15:0] MAC_CFG_RW_MASK = 16'hFBF3;
   localparam logic [1:0] TX_FIFO_DEPTH_RESET = 2'h1;

   localparam int POS_PWR = 8;
   localparam int POS_RX_SHIFT = 12;
   localparam int POS_TX_SHIFT = 11;
   localparam int POS_RGMII_EN = 9;
   localparam int POS_REF_50 = 7;
   localparam int POS_SLOW = 6;
   localparam int POS_RMII = 5;
   localparam int POS_OLD_REV = 4;
   localparam int POS_OVF = 3;
   localparam int POS_UNF = 2;
   localparam int POS_TX_DEPTH = 5;

   localparam logic [6:0] LOOP_RESERVED = 7'h01;
   localparam logic [6:0] LOOP_PCS = 7'h02;
   localparam logic [6:0] LOOP_DIGITAL = 7'h04;
   localparam logic [6:0] LOOP_ANALOG = 7'h08;
   localparam logic [6:0] LOOP_REVERSE = 7'h10;
   localparam logic [6:0] LOOP_REV_TO_MAC = 7'h20;
   localparam logic [6:0] LOOP_MAC_TO_LINE = 7'h40;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CRS_IDLE = 3'h1,
      CRS_ACTIVE = 3'h2,
      CRS_TAIL = 3'h4
   } crs_state_e;
endpackage : phy_cfg_pkg

// >>> src/phy_mac_cfg_loopback_regs.sv
// register bank: loopback select, core power state, MAC interface setup
// assumes an AXI4-Lite master on aclk; event inputs are one-cycle pulses
`timescale 1ns/1ps

// Contract
// - bit 8 of loopback register reads 1 in normal power, 0 asleep
// - loop code 0000010b loops transmit symbols into coding receive path
// - codes 0000100b/0001000b/0010000b give digital, analog, reverse loop
// - 0100000b forwards to MAC in reverse; 1000000b drives line in MAC loop
// - bit 12 set delays RGMII receive clock; clear keeps edges aligned
// - bit 11 set samples RGMII transmit data on shifted clock
// - bit 9 enables RGMII interface, resets to zero
// - bit 7 set means 50MHz reference input, clear means 25MHz
// - bit 6 set moves RMII master from 50MHz to 5MHz rate
// - bit 5 picks RMII or MII; software keeps RGMII enable clear
// - bit 4 set: carrier/valid toggles at packet end, rev 1.0 style
// - bit 4 clear: carrier/valid held high until last nibble, no toggle
// - bit 3 sticky RMII FIFO overflow, cleared by writing zero
// - bit 2 sticky RMII FIFO underflow, cleared by writing zero
// - elastic field sets drift tolerance bits and longest packet
// - transmit FIFO depth 4/5/6/8 nibbles, resets to 5
module phy_mac_cfg_loopback_regs
   import phy_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic core_power_normal,
   input wire logic rmii_fifo_overflow,
   input wire logic rmii_fifo_underflow,
   input wire logic rx_carrier,
   input wire logic rx_data_pending,
   output logic crs_dv,
   output logic loop_pcs,
   output logic loop_digital,
   output logic loop_analog,
   output logic loop_reverse,
   output logic loop_rev_to_mac,
   output logic loop_mac_to_line,
   output logic rgmii_rx_clk_delay,
   output logic rgmii_tx_clk_shift,
   output logic rgmii_enable,
   output logic reference_input_50mhz,
   output logic rmii_slow_5mhz,
   output logic rmii_select,
   output logic rmii_old_revision_select,
   output logic [3:0] elastic_tolerance_bits,
   output logic [14:0] elastic_max_packet,
   output logic [3:0] tx_fifo_nibbles,
   output logic irq
);

   logic aw_held_ff, w_held_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic [6:0] loop_mode_ff;
   logic pwr_normal_ff;
   logic [15:0] mac_cfg_ff;
   logic ovf_ff, unf_ff;
   logic [1:0] tx_depth_ff;
   logic [1:0] irq_status_ff, irq_mask_ff;
   crs_state_e crs_state_ff;
   logic do_write;

   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = a[ADDR_W-1:2];
   endfunction : word_index

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = word_index(a);
      addr_hit = (i == IDX_TX_FIFO_CFG) || (i == IDX_LOOPBACK) ||
                 (i == IDX_MAC_CFG) || (i == IDX_IRQ_STATUS) ||
                 (i == IDX_IRQ_MASK);
   endfunction : addr_hit

   // byte lanes 0 and 1 only; the registers are 16 bits wide
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic wr_to(input logic [7:0] idx);
      wr_to = do_write && (word_index(aw_addr_ff) == idx);
   endfunction : wr_to

   assign do_write = aw_held_ff && w_held_ff && !bvalid;

   // write address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held_ff <= 1'b1;
         aw_addr_ff <= awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end else if (!aw_held_ff && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held_ff <= 1'b1;
         w_data_ff <= wdata;
         w_strb_ff <= wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end else if (!w_held_ff && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= addr_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // read data is sampled at the address handshake, answered next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (word_index(araddr))
            IDX_LOOPBACK:
               rdata <= {16'h0000, 7'h00, pwr_normal_ff, 1'b0, loop_mode_ff};
            IDX_MAC_CFG:
               rdata <= {16'h0000, mac_cfg_ff[15:4], ovf_ff, unf_ff,
                         mac_cfg_ff[1:0]};
            IDX_TX_FIFO_CFG:
               rdata <= {25'h0000000, tx_depth_ff, 5'h00};
            IDX_IRQ_STATUS:
               rdata <= {30'h00000000, irq_status_ff};
            IDX_IRQ_MASK:
               rdata <= {30'h00000000, irq_mask_ff};
            default:
               rdata <= '0;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_normal_ff <= LOOPBACK_RESET[POS_PWR];
      end else begin
         pwr_normal_ff <= core_power_normal;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_mode_ff <= LOOPBACK_RESET[6:0];
      end else if (wr_to(IDX_LOOPBACK) && w_strb_ff[0]) begin
         loop_mode_ff <= w_data_ff[6:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mac_cfg_ff <= MAC_CFG_RESET & MAC_CFG_RW_MASK;
      end else if (wr_to(IDX_MAC_CFG)) begin
         mac_cfg_ff <= merge16(mac_cfg_ff, w_data_ff, w_strb_ff) &
                       MAC_CFG_RW_MASK;
      end
   end

   // overflow sticky, write zero clears; a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_ff <= MAC_CFG_RESET[POS_OVF];
      end else begin
         ovf_ff <= rmii_fifo_overflow | (ovf_ff & !(wr_to(IDX_MAC_CFG) &&
                   w_strb_ff[0] && !w_data_ff[POS_OVF]));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unf_ff <= MAC_CFG_RESET[POS_UNF];
      end else begin
         unf_ff <= rmii_fifo_underflow | (unf_ff & !(wr_to(IDX_MAC_CFG) &&
                   w_strb_ff[0] && !w_data_ff[POS_UNF]));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_depth_ff <= TX_FIFO_DEPTH_RESET;
      end else if (wr_to(IDX_TX_FIFO_CFG) && w_strb_ff[0]) begin
         tx_depth_ff <= w_data_ff[POS_TX_DEPTH +: 2];
      end
   end

   // interrupt status: bit 0 overflow, bit 1 underflow; write one clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= 2'h0;
         irq_mask_ff <= 2'h0;
         irq <= 1'b0;
      end else begin
         irq_status_ff <= {rmii_fifo_underflow, rmii_fifo_overflow} |
            (irq_status_ff & ~((wr_to(IDX_IRQ_STATUS) && w_strb_ff[0]) ?
             w_data_ff[1:0] : 2'h0));
         if (wr_to(IDX_IRQ_MASK) && w_strb_ff[0]) begin
            irq_mask_ff <= w_data_ff[1:0];
         end
         irq <= |(irq_status_ff & irq_mask_ff);
      end
   end

   // loop paths are independent flags; the reserved bit 0 drives nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_pcs <= 1'b0;
         loop_digital <= 1'b0;
         loop_analog <= 1'b0;
         loop_reverse <= 1'b0;
         loop_rev_to_mac <= 1'b0;
         loop_mac_to_line <= 1'b0;
      end else begin
         loop_pcs <= |(loop_mode_ff & LOOP_PCS);
         loop_digital <= |(loop_mode_ff & LOOP_DIGITAL);
         loop_analog <= |(loop_mode_ff & LOOP_ANALOG);
         loop_reverse <= |(loop_mode_ff & LOOP_REVERSE);
         loop_rev_to_mac <= |(loop_mode_ff & LOOP_REV_TO_MAC);
         loop_mac_to_line <= |(loop_mode_ff & LOOP_MAC_TO_LINE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rgmii_rx_clk_delay <= 1'b0;
         rgmii_tx_clk_shift <= 1'b0;
         rgmii_enable <= 1'b0;
         reference_input_50mhz <= 1'b0;
         rmii_slow_5mhz <= 1'b0;
         rmii_select <= 1'b0;
         rmii_old_revision_select <= 1'b0;
      end else begin
         rgmii_rx_clk_delay <= mac_cfg_ff[POS_RX_SHIFT];
         rgmii_tx_clk_shift <= mac_cfg_ff[POS_TX_SHIFT];
         rgmii_enable <= mac_cfg_ff[POS_RGMII_EN];
         reference_input_50mhz <= mac_cfg_ff[POS_REF_50];
         rmii_slow_5mhz <= mac_cfg_ff[POS_SLOW];
         rmii_select <= mac_cfg_ff[POS_RMII];
         rmii_old_revision_select <= mac_cfg_ff[POS_OLD_REV];
      end
   end

   // elastic buffer tolerance and packet length
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         elastic_tolerance_bits <= 4'h2;
         elastic_max_packet <= 15'h0960;
      end else begin
         unique case (mac_cfg_ff[1:0])
            2'h0: begin
               elastic_tolerance_bits <= 4'hE;
               elastic_max_packet <= 15'h41A0;
            end
            2'h1: begin
               elastic_tolerance_bits <= 4'h2;
               elastic_max_packet <= 15'h0960;
            end
            2'h2: begin
               elastic_tolerance_bits <= 4'h6;
               elastic_max_packet <= 15'h1C20;
            end
            2'h3: begin
               elastic_tolerance_bits <= 4'hA;
               elastic_max_packet <= 15'h2EE0;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_fifo_nibbles <= 4'h5;
      end else begin
         unique case (tx_depth_ff)
            2'h0: tx_fifo_nibbles <= 4'h4;
            2'h1: tx_fifo_nibbles <= 4'h5;
            2'h2: tx_fifo_nibbles <= 4'h6;
            2'h3: tx_fifo_nibbles <= 4'h8;
         endcase
      end
   end

   // carrier/valid: tail is carrier gone while data still drains
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crs_state_ff <= CRS_IDLE;
         crs_dv <= 1'b0;
      end else begin
         unique case (crs_state_ff)
            CRS_IDLE: begin
               crs_dv <= rx_carrier;
               if (rx_carrier) begin
                  crs_state_ff <= CRS_ACTIVE;
               end
            end
            CRS_ACTIVE: begin
               if (!rx_carrier && rx_data_pending) begin
                  crs_state_ff <= CRS_TAIL;
                  crs_dv <= !rmii_old_revision_select;
               end else if (!rx_carrier) begin
                  crs_state_ff <= CRS_IDLE;
                  crs_dv <= 1'b0;
               end else begin
                  crs_dv <= 1'b1;
               end
            end
            CRS_TAIL: begin
               if (!rx_data_pending) begin
                  crs_state_ff <= CRS_IDLE;
                  crs_dv <= 1'b0;
               end else if (rmii_old_revision_select) begin
                  crs_dv <= !crs_dv;
               end else begin
                  crs_dv <= 1'b1;
               end
            end
            default: begin
               crs_state_ff <= CRS_IDLE;
               crs_dv <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence read_loopback_s;
      arvalid && arready && word_index(araddr) == IDX_LOOPBACK;
   endsequence

   pwr_read_a: assert property (
      read_loopback_s |=> rvalid && rdata[POS_PWR] == $past(pwr_normal_ff))
      else $error("power state bit wrong on read");
   pcs_loop_a: assert property (
      loop_mode_ff == LOOP_PCS |=> loop_pcs && !loop_digital)
      else $error("coding loop not selected");
   loop_sel_a: assert property (
      loop_mode_ff == LOOP_ANALOG |=> loop_analog && !loop_reverse)
      else $error("analog loop not selected");
   loop_mod_a: assert property (
      loop_mode_ff == LOOP_MAC_TO_LINE |=> loop_mac_to_line && !loop_pcs)
      else $error("line modifier not selected");
   rx_shift_a: assert property (
      mac_cfg_ff[POS_RX_SHIFT] |=> rgmii_rx_clk_delay)
      else $error("receive delay not applied");
   rmii_sel_a: assert property (
      $rose(mac_cfg_ff[POS_RMII]) |=> rmii_select ##1 rmii_select)
      else $error("rmii select not following bit");
   ovf_sticky_a: assert property (
      rmii_fifo_overflow |=> ovf_ff && irq_status_ff[0])
      else $error("overflow not latched");
   unf_sticky_a: assert property (
      unf_ff && !do_write |=> unf_ff)
      else $error("underflow flag lost without write");

   sequence tail_drain_s;
      crs_state_ff == CRS_TAIL && rx_data_pending;
   endsequence

   crs_hold_a: assert property (
      tail_drain_s ##0 !rmii_old_revision_select |=> crs_dv)
      else $error("carrier valid dropped before last nibble");
   crs_toggle_a: assert property (
      tail_drain_s ##0 rmii_old_revision_select |=> crs_dv != $past(crs_dv))
      else $error("carrier valid not toggling");
   elastic_a: assert property (
      mac_cfg_ff[1:0] == 2'h0 |=> elastic_tolerance_bits == 4'hE)
      else $error("elastic tolerance wrong");
   fifo_depth_a: assert property (
      tx_depth_ff == 2'h3 |=> tx_fifo_nibbles == 4'h8)
      else $error("fifo depth wrong");

endmodule : phy_mac_cfg_loopback_regs

// >>> verif/mac_rx_source.sv
// receive-side source standing behind the MAC interface: one frame per go
// assumes go is a single-cycle pulse on aclk while the source is idle
`timescale 1ns/1ps
module mac_rx_source #(
   parameter int CARRIER_CYC = 6,
   parameter int TAIL_CYC = 4
) (
   input wire logic aclk,
   input wire logic go,
   output logic rx_carrier,
   output logic rx_data_pending,
   output logic busy
);
   int cnt_ff = 0;
   // carrier drops first; the data still draining keeps pending up
   assign rx_carrier = (cnt_ff >= 1) && (cnt_ff <= CARRIER_CYC);
   assign rx_data_pending = (cnt_ff >= 1) &&
                            (cnt_ff <= CARRIER_CYC + TAIL_CYC);
   assign busy = (cnt_ff != 0);
   always_ff @(posedge aclk) begin
      if (go && cnt_ff == 0) begin
         cnt_ff <= 1;
      end else if (cnt_ff == CARRIER_CYC + TAIL_CYC + 3) begin
         cnt_ff <= 0;
      end else if (cnt_ff != 0) begin
         cnt_ff <= cnt_ff + 1;
      end
   end
endmodule : mac_rx_source

// >>> verif/testbench.sv
// self-checking bench for the loopback and MAC interface register bank
// assumes the bank answers AXI4-Lite on aclk and the source model above
`timescale 1ns/1ps
module testbench
   import phy_cfg_pkg::*;
;
   localparam logic [9:0] A_LB = {IDX_LOOPBACK, 2'b00};
   localparam logic [9:0] A_MAC = {IDX_MAC_CFG, 2'b00};
   localparam logic [9:0] A_TXF = {IDX_TX_FIFO_CFG, 2'b00};
   localparam logic [9:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [9:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, crs_dv, irq, go, busy;
   logic [9:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, elastic_tolerance_bits, tx_fifo_nibbles;
   logic [1:0] bresp, rresp;
   logic [14:0] elastic_max_packet;
   logic core_power_normal, rmii_fifo_overflow, rmii_fifo_underflow;
   logic rx_carrier, rx_data_pending, loop_pcs, loop_digital, loop_analog;
   logic loop_reverse, loop_rev_to_mac, loop_mac_to_line, rgmii_enable;
   logic rgmii_rx_clk_delay, rgmii_tx_clk_shift, reference_input_50mhz;
   logic rmii_slow_5mhz, rmii_select, rmii_old_revision_select, crs_prev;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int rises;
   int pos[7] = '{12, 11, 9, 7, 6, 5, 4};
   int tol[4] = '{14, 2, 6, 10};
   int pkt[4] = '{16800, 2400, 7200, 12000};
   int nib[4] = '{4, 5, 6, 8};

   phy_mac_cfg_loopback_regs DUT (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
      .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
      .rresp, .core_power_normal, .rmii_fifo_overflow, .rmii_fifo_underflow,
      .rx_carrier, .rx_data_pending, .crs_dv, .loop_pcs, .loop_digital,
      .loop_analog, .loop_reverse, .loop_rev_to_mac, .loop_mac_to_line,
      .rgmii_rx_clk_delay, .rgmii_tx_clk_shift, .rgmii_enable,
      .reference_input_50mhz, .rmii_slow_5mhz, .rmii_select,
      .rmii_old_revision_select, .elastic_tolerance_bits,
      .elastic_max_packet, .tx_fifo_nibbles, .irq);
   mac_rx_source src (.aclk, .go, .rx_carrier, .rx_data_pending, .busy);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // let outputs that follow a register by one cycle land
   task automatic settle;
      repeat (2) @(posedge aclk);
      #1;
   endtask : settle

   task automatic wr(input logic [9:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            chk("bresp", bresp, er);
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   task automatic rdc(input logic [9:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            chk("rresp", rresp, er);
            chk("rdata", rdata, e);
            rready <= 1'b0;
            break;
         end
      end
   endtask : rdc

   task automatic pulse(input int e);
      @(posedge aclk);
      rmii_fifo_overflow <= (e == 0);
      rmii_fifo_underflow <= (e == 1);
      @(posedge aclk);
      rmii_fifo_overflow <= 1'b0;
      rmii_fifo_underflow <= 1'b0;
   endtask : pulse

   task automatic frame(input logic old_rev);
      wr(A_MAC, {16'h0, 11'h200, old_rev, 4'h1}, RESP_OKAY);
      @(posedge aclk);
      rises = 0;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      // busy only rises after this edge, so look from the next one on
      do begin
         @(posedge aclk);
      end while (busy !== 1'b0);
      settle();
   endtask : frame

   always @(posedge aclk) begin
      crs_prev <= crs_dv;
      if (crs_dv === 1'b1 && crs_prev === 1'b0) rises++;
      cycles++;
      // far longer than the whole sequence needs
      if (cycles == 6000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
      {rmii_fifo_overflow, rmii_fifo_underflow, crs_prev} = '0;
      {awaddr, araddr, wdata, awprot, arprot} = '0;
      wstrb = 4'hF;
      core_power_normal = 1'b1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      chk("elastic_tol", elastic_tolerance_bits, 32'h2);
      chk("fifo_nibbles", tx_fifo_nibbles, 32'h5);
      rdc(A_LB, 32'h100, RESP_OKAY);
      rdc(A_MAC, 32'h4001, RESP_OKAY);
      rdc(A_TXF, 32'h20, RESP_OKAY);
      $display("test reset done");
      // one path bit at a time, never the reserved code
      for (int i = 1; i < 7; i++) begin
         wr(A_LB, 32'(1 << i), RESP_OKAY);
         settle();
         chk("loop_out", {loop_mac_to_line, loop_rev_to_mac, loop_reverse,
            loop_analog, loop_digital, loop_pcs},
            32'(1 << (i - 1)));
         rdc(A_LB, 32'(1 << i) | 32'h100, RESP_OKAY);
      end
      wr(A_LB, 32'h0, RESP_OKAY);
      core_power_normal <= 1'b0;
      rdc(A_LB, 32'h0, RESP_OKAY);
      core_power_normal <= 1'b1;
      $display("test loopback done");
      // rgmii enable stays clear in the entry that picks rmii
      for (int k = 0; k < 7; k++) begin
         wr(A_MAC, 32'h4000 | 32'(1 << pos[k]) | 32'(k % 4), RESP_OKAY);
         settle();
         chk("mac_out", {rgmii_rx_clk_delay, rgmii_tx_clk_shift,
            rgmii_enable, reference_input_50mhz, rmii_slow_5mhz,
            rmii_select, rmii_old_revision_select},
            32'(7'h40 >> k));
         chk("elastic_tol", elastic_tolerance_bits, tol[k % 4]);
         chk("elastic_pkt", elastic_max_packet, pkt[k % 4]);
         rdc(A_MAC, 32'h4000 | 32'(1 << pos[k]) | 32'(k % 4),
            RESP_OKAY);
      end
      for (int d = 0; d < 4; d++) begin
         wr(A_TXF, 32'(d << 5), RESP_OKAY);
         settle();
         chk("fifo_nibbles", tx_fifo_nibbles, nib[d]);
      end
      $display("test mac config done");
      for (int e = 0; e < 2; e++) begin
         wr(A_MAC, 32'h4001, RESP_OKAY);
         pulse(e);
         settle();
         chk("irq_masked", irq, 32'h0);
         rdc(A_MAC, 32'h4001 | 32'(8 >> e), RESP_OKAY);
         rdc(A_ST, 32'(1 << e), RESP_OKAY);
         wr(A_MSK, 32'(1 << e), RESP_OKAY);
         settle();
         chk("irq_on", irq, 32'h1);
         wr(A_MAC, 32'h400D, RESP_OKAY);
         rdc(A_MAC, 32'h4001 | 32'(8 >> e), RESP_OKAY);
         wr(A_MAC, 32'h4001, RESP_OKAY);
         rdc(A_MAC, 32'h4001, RESP_OKAY);
         wr(A_ST, 32'(1 << e), RESP_OKAY);
         settle();
         chk("irq_off", irq, 32'h0);
         wr(A_MSK, 32'h0, RESP_OKAY);
      end
      $display("test sticky flags done");
      wr(10'h3FC, 32'hFFFF, RESP_SLVERR);
      rdc(10'h3FC, 32'h0, RESP_SLVERR);
      rdc(A_MAC, 32'h4001, RESP_OKAY);
      $display("test unmapped done");
      frame(1'b0);
      chk("crs_rises_new", rises, 32'h1);
      chk("crs_idle", crs_dv, 32'h0);
      frame(1'b1);
      chk("crs_toggles_old", 32'(rises > 1), 32'h1);
      chk("crs_idle", crs_dv, 32'h0);
      $display("test carrier done");
      close_out();
   end
endmodule : testbench
